// >>> hw/sac_cfg.svh
/*
 * Constants of the converter control and readout block: result width,
 * conversion, acquisition and wake timing, and reset values of the
 * synchronised pins.
 * Assumes the including file runs on the 200 MHz system clock.
 */
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// -----------------------------------------------------------------
// Clock and result
// -----------------------------------------------------------------
`define SAC_CLK_PERIOD_NS   5
`define SAC_RESULT_BITS     16
`define SAC_BYTE_BITS       8

// -----------------------------------------------------------------
// Timing, in ns as printed, then in cycles
// -----------------------------------------------------------------
`define SAC_CONV_TIME_NS    1300
`define SAC_ACQ_TIME_NS     685
`define SAC_RST_EXTRA_NS    1000
`define SAC_NAP_WAKE_NS     250
// Longest times round down, least times round up
`define SAC_CONV_CYCLES     (`SAC_CONV_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_STEP_CYCLES     (`SAC_CONV_CYCLES / `SAC_RESULT_BITS)
`define SAC_ACQ_CYCLES      (`SAC_ACQ_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_SETTLE_CYCLES   ((`SAC_ACQ_TIME_NS + `SAC_RST_EXTRA_NS) / `SAC_CLK_PERIOD_NS)
`define SAC_WAKE_CYCLES     ((`SAC_NAP_WAKE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define SAC_PINS_RESET      9'h1e3
`define SAC_MSB_TRIAL       16'h8000
`define SAC_RESULT_RESET    16'h0000

`endif

// >>> hw/sac_pkg.sv
/*
 * Types of the converter control and readout block.
 * Assumes sac_cfg.svh for all numeric constants.
 */
package sac_pkg;

    // -------------------------------------------------------------
    // Pins from outside the clock domain, synchronised as one word
    // -------------------------------------------------------------
    typedef struct packed {
        logic conv_rst;     // Converter reset, active high
        logic cs_n;
        logic rd_n;
        logic cnv_n;        // conversion_start_n
        logic sclk;
        logic ser;          // interface_select
        logic swap;         // byte_order_flip
        logic fmt;          // output_format_select
        logic chain;        // chain_data_in
    } sac_pins_t;

    // -------------------------------------------------------------
    // Conversion sequencer
    // -------------------------------------------------------------
    typedef enum logic [0:0] {
        sac_idle    = 1'b0,
        sac_convert = 1'b1
    } sac_state_t;

endpackage

// >>> hw/sac_sync.sv
/*
 * Three-stage synchroniser with agreement filter for a word of pins.
 * Assumes every bit is an independent level from outside the domain.
 */
`timescale 1ns/1ps

module sac_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             mclk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    // -------------------------------------------------------------
    // Synchroniser chain
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            meta_reg   <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end
        else
        begin
            meta_reg   <= async_in;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // -------------------------------------------------------------
    // Agreement filter, one per bit
    // -------------------------------------------------------------
    // A glitch shorter than one cycle never reaches the level
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge mclk_in)
        begin
            if (!resetn_in)
                level_reg[i] <= RESET_VAL[i];
            else if (stage2_reg[i] == stage3_reg[i])
                level_reg[i] <= stage3_reg[i];
        end
    end

    assign level_out = level_reg;

endmodule

// >>> hw/sac_top.sv
/*
 * Conversion sequencer and parallel/serial readout of a 16-bit
 * successive approximation converter.
 * Assumes an analog front end that answers comparator_in for the
 * trial code on dac_trial_out within one cycle, and a board that
 * resolves the pin levels from the output enables.
 */
// Overview of operation
// - A falling edge of conversion_start_n starts a conversion.
// - Start edges during a conversion are ignored.
// - Busy is high exactly while a conversion runs.
// - Conversions are timed internally and finish within 1300ns.
// - Acquisition needs at most 685ns; 500ksps throughput results.
// - Parallel bus drives only with serial select low, select and read low.
// - Byte flip low: upper result byte on upper bus byte.
// - Byte flip high: lower result byte on upper bus byte.
// - Serial select high with select and read low enables serial out.
// - Serial output changes on rising shift clock; host samples falling.
// - The MSB holds until the first rising edge after a falling.
// - In serial mode the unused outputs float.
// - Chain input data follows own bits on the serial output.
// - The first chain bit is caught on the first falling shift edge.
// - Format select low inverts the MSB for two's complement.
// - Converter reset aborts a conversion and floats the data bus.
// - Converter reset ignores start requests.
// - Select or read high floats all data outputs.
// - Nap: start kept low, then high 250ns before next start.
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_top #(
    parameter int BITS          = `SAC_RESULT_BITS,
    parameter int STEP_CYCLES   = `SAC_STEP_CYCLES,
    parameter int ACQ_CYCLES    = `SAC_ACQ_CYCLES,
    parameter int SETTLE_CYCLES = `SAC_SETTLE_CYCLES,
    parameter int WAKE_CYCLES   = `SAC_WAKE_CYCLES
) (
    input  wire logic            mclk_in,
    input  wire logic            resetn_in,
    input  wire logic            converter_reset_in,
    input  wire logic            conversion_start_n_in,
    input  wire logic            cs_n_in,
    input  wire logic            rd_n_in,
    input  wire logic            interface_select_in,
    input  wire logic            byte_order_flip_in,
    input  wire logic            output_format_select_in,
    input  wire logic            sclk_in,
    input  wire logic            chain_data_in,
    input  wire logic            comparator_in,
    output logic      [BITS-1:0] dac_trial_out,
    output logic                 busy_out,
    output logic                 acquiring_out,
    output logic                 nap_out,
    output logic      [BITS-1:0] data_out,
    output logic      [BITS-1:0] data_oe_out,
    output logic                 serial_result_out,
    output logic                 serial_result_oe_out
);

    localparam int HB       = BITS / 2;
    localparam int CONV_LEN = BITS * STEP_CYCLES;

    sac_pkg::sac_pins_t pins_raw;
    sac_pkg::sac_pins_t pins_s;
    sac_pkg::sac_state_t state_reg;
    logic [BITS-1:0] trial_reg;
    logic [BITS-1:0] sar_next;
    logic [BITS-1:0] result_reg;
    logic [BITS-1:0] fmt_word;
    logic [BITS-1:0] par_data_reg;
    logic [BITS-1:0] shift_reg;
    logic [3:0]      bit_idx_reg;
    logic [8:0]      step_cnt_reg;
    logic [8:0]      acq_cnt_reg;
    logic [8:0]      wake_cnt_reg;
    logic            cnv_prev_reg;
    logic            sclk_prev_reg;
    logic            armed_reg;
    logic            chain_bit_reg;
    logic            nap_reg;
    logic            start_fall;
    logic            sclk_rise;
    logic            sclk_fall;
    logic            step_end;
    logic            conv_done;
    logic            read_sel;
    logic            ser_en;
    logic            par_en;

    // -------------------------------------------------------------
    // Pin synchronisation
    // -------------------------------------------------------------
    assign pins_raw = '{conv_rst: converter_reset_in,
                        cs_n:     cs_n_in,
                        rd_n:     rd_n_in,
                        cnv_n:    conversion_start_n_in,
                        sclk:     sclk_in,
                        ser:      interface_select_in,
                        swap:     byte_order_flip_in,
                        fmt:      output_format_select_in,
                        chain:    chain_data_in};

    sac_sync #(
        .WIDTH     ($bits(sac_pkg::sac_pins_t)),
        .RESET_VAL (`SAC_PINS_RESET)
    ) u_sync (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .async_in  (pins_raw),
        .level_out (pins_s)
    );

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            cnv_prev_reg  <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            cnv_prev_reg  <= pins_s.cnv_n;
            sclk_prev_reg <= pins_s.sclk;
        end
    end

    assign start_fall = cnv_prev_reg & ~pins_s.cnv_n;
    assign sclk_rise  = ~sclk_prev_reg & pins_s.sclk;
    assign sclk_fall  = sclk_prev_reg & ~pins_s.sclk;

    // -------------------------------------------------------------
    // Successive approximation sequencer
    // -------------------------------------------------------------
    assign step_end  = (state_reg == sac_pkg::sac_convert)
                       && (step_cnt_reg == 9'h000);
    assign conv_done = step_end && (bit_idx_reg == 4'h0);

    always_comb
    begin
        sar_next = trial_reg;
        if (!comparator_in)
            sar_next[bit_idx_reg] = 1'b0;
        if (bit_idx_reg != 4'h0)
            sar_next[bit_idx_reg - 4'h1] = 1'b1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in || pins_s.conv_rst)
        begin
            state_reg    <= sac_pkg::sac_idle;
            trial_reg    <= `SAC_MSB_TRIAL;
            bit_idx_reg  <= 4'hf;
            step_cnt_reg <= 9'h000;
        end
        else
        begin
            unique case (state_reg)
                sac_pkg::sac_idle:
                begin
                    if (start_fall)
                    begin
                        state_reg    <= sac_pkg::sac_convert;
                        trial_reg    <= `SAC_MSB_TRIAL;
                        bit_idx_reg  <= 4'(BITS - 1);
                        step_cnt_reg <= 9'(STEP_CYCLES - 1);
                    end
                end
                sac_pkg::sac_convert:
                begin
                    // Start edges fall through here unseen
                    if (step_end)
                    begin
                        trial_reg <= sar_next;
                        if (conv_done)
                            state_reg <= sac_pkg::sac_idle;
                        else
                        begin
                            bit_idx_reg  <= bit_idx_reg - 4'h1;
                            step_cnt_reg <= 9'(STEP_CYCLES - 1);
                        end
                    end
                    else
                        step_cnt_reg <= step_cnt_reg - 9'h001;
                end
            endcase
        end
    end

    assign busy_out      = (state_reg == sac_pkg::sac_convert);
    assign dac_trial_out = trial_reg;

    // -------------------------------------------------------------
    // Acquisition window and nap
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in || pins_s.conv_rst)
            acq_cnt_reg <= 9'(SETTLE_CYCLES);
        else if (conv_done)
            acq_cnt_reg <= 9'(ACQ_CYCLES);
        else if (acq_cnt_reg != 9'h000)
            acq_cnt_reg <= acq_cnt_reg - 9'h001;
    end

    assign acquiring_out = (acq_cnt_reg != 9'h000);

    // Wake time is only reported; an early start still converts
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in || pins_s.conv_rst)
        begin
            nap_reg      <= 1'b0;
            wake_cnt_reg <= 9'h000;
        end
        else
        begin
            if (conv_done && !pins_s.cnv_n)
                nap_reg <= 1'b1;
            else if (wake_cnt_reg == 9'(WAKE_CYCLES - 1))
                nap_reg <= 1'b0;
            if (!nap_reg || !pins_s.cnv_n)
                wake_cnt_reg <= 9'h000;
            else
                wake_cnt_reg <= wake_cnt_reg + 9'h001;
        end
    end

    assign nap_out = nap_reg;

    // -------------------------------------------------------------
    // Result holder and format
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
            result_reg <= `SAC_RESULT_RESET;
        else if (conv_done)
            result_reg <= sar_next;
    end

    // Offset binary is native; low format flips the MSB
    assign fmt_word = {result_reg[BITS-1] ^ ~pins_s.fmt,
                       result_reg[BITS-2:0]};

    // -------------------------------------------------------------
    // Parallel readout
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
            par_data_reg <= `SAC_RESULT_RESET;
        else if (pins_s.swap)
            par_data_reg <= {fmt_word[HB-1:0], fmt_word[BITS-1:HB]};
        else
            par_data_reg <= fmt_word;
    end

    // Raw reset pin floats the bus at once, before synchronisation
    assign read_sel = ~pins_s.cs_n & ~pins_s.rd_n
                      & ~pins_s.conv_rst & ~converter_reset_in;
    assign par_en   = read_sel & ~pins_s.ser;
    assign ser_en   = read_sel & pins_s.ser;
    assign data_out    = par_data_reg;
    assign data_oe_out = {BITS{par_en}};

    // -------------------------------------------------------------
    // Serial readout and daisy chain
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
            chain_bit_reg <= 1'b0;
        else if (ser_en && sclk_fall)
            chain_bit_reg <= pins_s.chain;
    end

    // A fresh result wins over any shift in the same cycle
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            shift_reg <= `SAC_RESULT_RESET;
            armed_reg <= 1'b0;
        end
        else if (conv_done)
        begin
            shift_reg <= {sar_next[BITS-1] ^ ~pins_s.fmt,
                          sar_next[BITS-2:0]};
            armed_reg <= 1'b0;
        end
        else if (ser_en)
        begin
            if (sclk_fall)
                armed_reg <= 1'b1;
            if (sclk_rise && armed_reg)
                shift_reg <= {shift_reg[BITS-2:0], chain_bit_reg};
        end
    end

    assign serial_result_out    = shift_reg[BITS-1];
    assign serial_result_oe_out = ser_en;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    int unsigned busy_len;
    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in || !busy_out)
            busy_len <= 0;
        else
            busy_len <= busy_len + 1;
    end

    sequence s_start;
        start_fall && !busy_out && !pins_s.conv_rst;
    endsequence

    sequence s_mid_start;
        start_fall && busy_out && !pins_s.conv_rst && !conv_done;
    endsequence

    a_start_busy: assert property (s_start |=> busy_out &&
        trial_reg == `SAC_MSB_TRIAL)
        else $error("start edge did not launch a conversion");
    a_start_ignored: assert property (s_mid_start
        |=> busy_out && $stable(bit_idx_reg) || $changed(trial_reg))
        else $error("start edge disturbed a running conversion");
    a_busy_length: assert property (busy_out |->
        busy_len < BITS * STEP_CYCLES)
        else $error("conversion ran too long");
    // A converter reset cuts the conversion short, so it drops the check
    a_conv_bound: assert property (disable iff
        (!resetn_in || pins_s.conv_rst) s_start ##1 busy_out
        |-> ##[CONV_LEN:CONV_LEN] !busy_out)
        else $error("conversion time off");
    a_bus_exclusive: assert property (!(par_en && ser_en))
        else $error("parallel and serial outputs driven together");
    a_swap_bytes: assert property ($past(pins_s.swap) |->
        par_data_reg[HB-1:0] == $past(fmt_word[BITS-1:HB]))
        else $error("byte flip not applied");
    a_straight_bytes: assert property (!$past(pins_s.swap) |->
        par_data_reg == $past(fmt_word))
        else $error("straight byte order broken");
    a_msb_hold: assert property (!armed_reg && !conv_done
        |=> $stable(shift_reg))
        else $error("MSB moved before first falling edge");
    a_chain_shift: assert property (ser_en && sclk_rise && armed_reg
        && !conv_done |=> shift_reg[0] == $past(chain_bit_reg))
        else $error("chain bit not shifted in");
    a_format_load: assert property (conv_done |=>
        shift_reg[BITS-1] == ($past(sar_next[BITS-1]) ^ !$past(pins_s.fmt)))
        else $error("format bit wrong at load");
    // The bus may drive again in the same cycle the synchronised reset level drops
    a_reset_abort: assert property (pins_s.conv_rst |->
        data_oe_out == '0 ##1 !busy_out)
        else $error("converter reset did not abort");
    a_result_load: assert property (conv_done |=>
        result_reg == $past(sar_next) && !busy_out)
        else $error("result not loaded at conversion end");

endmodule

// >>> tb/sac_host_model.sv
/*
 * Host model: shift clock frames fed from an upstream chained device,
 * plus an ideal analog front end answering the trial code.
 * Assumes frames are asked for only while the serial port is selected.
 */
`timescale 1ns/1ps

module sac_host_model (
    input  wire logic        mclk_in,
    input  wire logic        frame_in,
    input  wire logic [15:0] chain_word_in,
    input  wire logic [15:0] analog_code_in,
    input  wire logic [15:0] dac_trial_in,
    input  wire logic        serial_result_in,
    output logic             sclk_out,
    output logic             chain_out,
    output logic             comparator_out,
    output logic [31:0]      word_out,
    output logic             word_valid_out
);
    int k;

    assign comparator_out = (analog_code_in >= dac_trial_in);

    // Shift clock stands low between frames
    initial
    begin
        sclk_out = 1'b0;
        chain_out = 1'b0;
        word_out = '0;
        word_valid_out = 1'b0;
        forever
        begin
            @(posedge mclk_in iff frame_in);
            #1.3;
            // 48 ns period: slower than full throughput needs, a limitation
            for (k = 1; k <= 32; k++)
            begin
                sclk_out = 1'b1;
                // Upstream changes on rising edges; junk after its word
                if (k <= 16)
                    chain_out = chain_word_in[16-k];
                else
                    chain_out = ~chain_out;
                #24;
                sclk_out = 1'b0;
                // Late in the low phase: the pin reaches the output
                // through a synchroniser, some five system clocks late
                #23;
                word_out = {word_out[30:0], serial_result_in};
                #1;
            end
            @(posedge mclk_in);
            word_valid_out <= 1'b1;
            @(posedge mclk_in);
            word_valid_out <= 1'b0;
        end
    end
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench of the converter sequencer and readout.
 * Assumes sac_host_model on the far side and shortened counts.
 */
`timescale 1ns/1ps
`define CHECK(g, e) check_val(32'(g), 32'(e))

module testbench;
    localparam int STEP = 2;
    localparam int ACQ  = 20;
    localparam int CONV = 16 * STEP;
    localparam int WAKE = 4;

    logic        mclk = 1'b0, resetn = 1'b0, conv_rst = 1'b0;
    logic        cnv_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1, ser = 1'b0;
    logic        swap = 1'b0, fmt = 1'b1, frame = 1'b0, par_take = 1'b0;
    logic [15:0] analog = 16'h0000, chain_w = 16'h0000;
    logic        sclk, chain, comp, busy, acq, nap, sro, sro_oe, word_valid;
    logic [15:0] dac, data, data_oe;
    logic [31:0] word;
    logic [31:0] exp_q[$];
    int          fail_count = 0, compares = 0, cycles = 0;
    int          seed = 32'h1fe42e1c;

    sac_top #(.STEP_CYCLES(STEP), .ACQ_CYCLES(ACQ), .SETTLE_CYCLES(10),
              .WAKE_CYCLES(WAKE)) i_sac_top (
        .mclk_in(mclk), .resetn_in(resetn), .converter_reset_in(conv_rst),
        .conversion_start_n_in(cnv_n), .cs_n_in(cs_n), .rd_n_in(rd_n),
        .interface_select_in(ser), .byte_order_flip_in(swap),
        .output_format_select_in(fmt), .sclk_in(sclk),
        .chain_data_in(chain), .comparator_in(comp), .dac_trial_out(dac),
        .busy_out(busy), .acquiring_out(acq), .nap_out(nap),
        .data_out(data), .data_oe_out(data_oe),
        .serial_result_out(sro), .serial_result_oe_out(sro_oe));

    sac_host_model host (
        .mclk_in(mclk), .frame_in(frame), .chain_word_in(chain_w),
        .analog_code_in(analog), .dac_trial_in(dac),
        .serial_result_in(sro), .sclk_out(sclk), .chain_out(chain),
        .comparator_out(comp), .word_out(word),
        .word_valid_out(word_valid));

    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] ex);
        compares++;
        if (got !== ex)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask

    task automatic complete_run;
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [15:0] shown(input logic [15:0] c,
                                          input logic f, input logic s);
        logic [15:0] v;
        v = f ? c : {~c[15], c[14:0]};
        return s ? {v[7:0], v[15:8]} : v;
    endfunction

    // ------------------------------------------------------------
    // Conversion: 0 plain, 1 second start mid-way, 2 nap, 3 mid read
    // ------------------------------------------------------------
    task automatic convert(input logic [15:0] code, input int mode);
        int i;
        int n;
        int m;
        n = 0;
        m = 0;
        analog <= code;
        cnv_n <= 1'b0;
        for (i = 0; i < 80; i++)
        begin
            @(posedge mclk);
            // Start returned high after 35 ns, inside the 40 ns limit
            if (mode != 2)
                cnv_n <= !(i < 6 || (mode == 1 && i >= 14 && i < 20));
            par_take <= (mode == 3 && i == 12);
            @(negedge mclk);
            if (busy === 1'b1)
                n++;
            else if (n > 0)
                break;
        end
        `CHECK(n, CONV);
        `CHECK(acq, 1'b1);
        for (i = 0; i < ACQ + 2; i++)
        begin
            @(negedge mclk);
            if (busy !== 1'b0)
                m++;
        end
        `CHECK(m, 0);
        `CHECK(acq, 1'b0);
        if (mode == 2)
        begin
            `CHECK(nap, 1'b1);
            @(posedge mclk);
            cnv_n <= 1'b1;
            repeat (WAKE + 8) @(negedge mclk);
            `CHECK(nap, 1'b0);
        end
        @(posedge mclk);
    endtask

    task automatic par_read(input logic [15:0] v);
        ser <= 1'b0;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (8) @(posedge mclk);
        exp_q.push_back({16'h0, v});
        par_take <= 1'b1;
        @(posedge mclk);
        par_take <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(negedge mclk)
    begin
        if (par_take === 1'b1 || word_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                fail_count++;
                $display("[FAIL] t=%0t got=%h exp=none", $time, data);
            end
            else if (par_take === 1'b1)
            begin
                `CHECK(data_oe, 16'hffff);
                `CHECK({16'h0, data}, exp_q.pop_front());
            end
            else
                `CHECK(word, exp_q.pop_front());
        end
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            complete_run();
        end
    end

    initial
    begin
        logic [15:0] code;
        logic [15:0] prev;
        int k;
        prev = 16'h0000;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (40) @(posedge mclk);
        for (k = 0; k < 8; k++)
        begin
            {ser, cs_n, rd_n} <= 3'(k);
            repeat (8) @(posedge mclk);
            @(negedge mclk);
            `CHECK(data_oe, (k == 0) ? 16'hffff : 16'h0000);
            `CHECK(sro_oe, k == 4);
            @(posedge mclk);
        end
        for (k = 0; k < 4; k++)
        begin
            code = 16'($random(seed));
            swap <= k[0];
            fmt <= k[1];
            if (k > 0)
                exp_q.push_back({16'h0, shown(prev, k[1], k[0])});
            convert(code, (k > 0) ? 3 : 0);
            par_read(shown(code, k[1], k[0]));
            prev = code;
        end
        code = 16'($random(seed));
        convert(code, 1);
        par_read(shown(code, 1'b1, 1'b1));
        convert(code, 2);
        // Serial frames after conversion, select held for the frame
        for (k = 0; k < 2; k++)
        begin
            code = 16'($random(seed));
            fmt <= k[0];
            ser <= 1'b1;
            convert(code, 0);
            chain_w <= 16'($random(seed));
            @(posedge mclk);
            exp_q.push_back({shown(code, k[0], 1'b0), chain_w});
            frame <= 1'b1;
            @(posedge mclk);
            frame <= 1'b0;
            repeat (360) @(posedge mclk);
        end
        // Converter reset in mid-conversion, start refused meanwhile
        ser <= 1'b0;
        cnv_n <= 1'b0;
        repeat (12) @(posedge mclk);
        conv_rst <= 1'b1;
        cnv_n <= 1'b1;
        @(negedge mclk);
        `CHECK(data_oe, 16'h0000);
        @(posedge mclk);
        repeat (10) @(posedge mclk);
        cnv_n <= 1'b0;
        repeat (10) @(negedge mclk);
        `CHECK(busy, 1'b0);
        @(posedge mclk);
        conv_rst <= 1'b0;
        cnv_n <= 1'b1;
        repeat (60) @(posedge mclk);
        code = 16'($random(seed));
        convert(code, 0);
        par_read(shown(code, 1'b1, 1'b1));
        repeat (4) @(posedge mclk);
        complete_run();
    end
endmodule
